// *** src/lsr_baud_gen.sv ***
/*
  Fractional divider making the 16x oversampling tick from the CPU clock.
  Assumes the divisor is 8.4 fixed point; a zero integer part stops the tick.
*/
`timescale 1ns/10ps
module lsr_baud_gen import lsr_pkg::*; #(
  parameter int MANT_W = 8,
  parameter int FRAC_W = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic [MANT_W+FRAC_W-1:0] divisor,
  input wire logic realign,
  // Tick
  output logic tick
);
  localparam int AW = MANT_W + FRAC_W + 1;
  localparam logic [AW-1:0] ONE = AW'(1 << FRAC_W);

  logic [AW-1:0] acc_q;
  logic [AW-1:0] acc_nx;
  logic run;

  assign run = divisor[MANT_W+FRAC_W-1:FRAC_W] != '0;
  assign acc_nx = acc_q + ONE;
  // One tick per divisor CPU cycles on average: bit rate is fcpu/(16*divisor)
  assign tick = run && !realign && (acc_nx >= {1'b0, divisor});

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= '0;
    end else if (!run || realign) begin
      acc_q <= '0;
    end else if (tick) begin
      acc_q <= acc_nx - {1'b0, divisor};
    end else begin
      acc_q <= acc_nx;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_tick_off_zero: assert property (!run |-> !tick)
    else $error("tick with zero divisor");
  a_tick_spacing: assert property (tick && divisor >= 12'h020 |=> !tick)
    else $error("ticks closer than the divisor allows");
  a_realign_blank: assert property (realign |-> !tick ##1 (acc_q == '0))
    else $error("realign did not restart the phase");
endmodule

// *** src/lsr_defs.svh ***
/*
  Offsets, field positions, reset values and counts of the LIN slave receiver.
  Assumes byte offsets are taken from haddr[7:0] of a word-aligned AHB-Lite access.
*/
`ifndef LSR_DEFS_SVH
`define LSR_DEFS_SVH
`define LSR_OFS_STATUS 8'h00
`define LSR_OFS_DATA 8'h04
`define LSR_OFS_CR1 8'h08
`define LSR_OFS_CR2 8'h0c
`define LSR_OFS_LINCR 8'h10
`define LSR_OFS_DIVM 8'h14
`define LSR_OFS_DIVF 8'h18
`define LSR_OFS_SMEAS 8'h1c
`define LSR_STATUS_RST 8'hc0
`define LSR_CR1_RST 7'h00
`define LSR_CR2_RST 8'h00
`define LSR_LINCR_RST 4'h0
`define LSR_CR1_PCE 2
`define LSR_CR1_RSV 1
`define LSR_CR1_PIE 0
`define LSR_CR2_RIE 5
`define LSR_CR2_MUTE 1
`define LSR_LIN_EN 6
`define LSR_LIN_SLV 5
`define LSR_LIN_HDM 3
`define LSR_LIN_HIE 2
`define LSR_LIN_HDF 1
`define LSR_LIN_LSF 0
`define LSR_OVS 16
`define LSR_SAMP_FIRST 4'h7
`define LSR_SAMP_LAST 4'h9
`define LSR_BRK_BITS 11
`define LSR_HDR_TMO_BITS 57
`define LSR_IDLE_BITS 10
`define LSR_SYNC_EDGES 5
`endif

// *** src/lsr_pkg.sv ***
/*
  Types shared by the LIN slave receiver modules.
  Assumes the constants of lsr_defs.svh.
*/
package lsr_pkg;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_START = 2'b01,
    CH_DATA = 2'b10,
    CH_STOP = 2'b11
  } lsr_char_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SYNC = 2'b01,
    H_GAP = 2'b10,
    H_ID = 2'b11
  } lsr_hdr_e;
  typedef struct packed {
    logic rx_full;
    logic idle;
    logic hdr_err;
    logic noise;
    logic frame_err;
    logic par_err;
  } lsr_flags_s;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] ofs;
  } lsr_ahb_req_s;
endpackage

// *** src/lsr_receiver.sv ***
/*
  LIN slave receive logic with status and control registers on AHB-Lite.
  Assumes one 40 MHz clock, an asynchronous rx_line from the transceiver and a
  single AHB-Lite master doing whole-word single transfers.
*/
// The register addresses and the AHB-Lite interface to the registers were decided locally.
// Functional notes
// - Break needs eleven consecutive low bit times
// - All-zero character never counts as break
// - Each bit oversampled sixteen times
// - Bit value is majority of samples 8-10
// - Sample phase restarts on every start bit
// - Synch length measured over eight bit times
// - Synch counter and edges on CPU clock
// - Baud rate steps of one sixteenth divisor
// - Muted slave discards bits until break, or until identifier with the identifier method
// - Mute wakes on break or identifier, selectable
// - Status resets to c0, fixed bit order
// - Header error: synch corrupt, timeout, overrun
// - Header error interrupts when rx irq enabled
// - Clear synch state before header error clears
// - Outside headers header error means overrun
// - Noise flag only meaningful in master mode
// - Slave framing error needs some recessive bit
// - Break sets header detect, not framing error; the identifier method sets header detect on identifier
// - Framing error clears: status then data read
// - Identifier parity error flag, clear, interrupt
// - Control one: bit2 parity enable, bit1 reserved
// - Slave rate is fcpu/(16*8.4 divisor)
// - Synch state set on break, cleared after
`timescale 1ns/10ps
`include "lsr_defs.svh"
module lsr_receiver import lsr_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // LIN line and interrupt
  input wire logic rx_line,
  output logic serial_irq
);
  localparam logic [7:0] BRK_TICKS = 8'(`LSR_BRK_BITS * `LSR_OVS);
  localparam logic [7:0] IDLE_TICKS = 8'(`LSR_IDLE_BITS * `LSR_OVS);
  localparam logic [9:0] TMO_TICKS = 10'(`LSR_HDR_TMO_BITS * `LSR_OVS);
  localparam logic [2:0] LAST_EDGE = 3'(`LSR_SYNC_EDGES - 1);
  localparam logic [7:0] STATUS_RST = `LSR_STATUS_RST;

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic id_parity_ok(input logic [7:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return (id[6] == p0) && (id[7] == p1);
  endfunction

  // Bus front end: zero wait states, read data registered in the address phase
  lsr_ahb_req_s req;
  lsr_ahb_req_s wreq_q;
  logic [31:0] hrdata_q;
  logic rd_status, rd_data, rd_lincr, wr_cr1, wr_cr2, wr_lincr, wr_divm, wr_divf;

  assign req.rd = hsel && hready && htrans[1] && !hwrite;
  assign req.wr = hsel && hready && htrans[1] && hwrite;
  assign req.ofs = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign rd_status = req.rd && req.ofs == `LSR_OFS_STATUS;
  assign rd_data = req.rd && req.ofs == `LSR_OFS_DATA;
  assign rd_lincr = req.rd && req.ofs == `LSR_OFS_LINCR;
  assign wr_cr1 = wreq_q.wr && wreq_q.ofs == `LSR_OFS_CR1;
  assign wr_cr2 = wreq_q.wr && wreq_q.ofs == `LSR_OFS_CR2;
  assign wr_lincr = wreq_q.wr && wreq_q.ofs == `LSR_OFS_LINCR;
  assign wr_divm = wreq_q.wr && wreq_q.ofs == `LSR_OFS_DIVM;
  assign wr_divf = wreq_q.wr && wreq_q.ofs == `LSR_OFS_DIVF;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wreq_q <= '0;
    end else begin
      wreq_q <= req;
    end
  end

  // Software registers
  logic [6:0] cr1_q;
  logic rx_ninth_q;
  logic [7:0] cr2_q;
  logic mute_q;
  logic [3:0] lincr_q;
  logic [7:0] div_m_q;
  logic [3:0] div_f_q;
  logic lin_en, slave_mode, master_mode, hdr_method, lsf_q, hdf_q;

  assign lin_en = lincr_q[3];
  assign slave_mode = lin_en && lincr_q[2];
  assign master_mode = lin_en && !lincr_q[2];
  assign hdr_method = lincr_q[1];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cr1_q <= `LSR_CR1_RST;
      cr2_q <= `LSR_CR2_RST;
      lincr_q <= `LSR_LINCR_RST;
      div_m_q <= 8'h00;
      div_f_q <= 4'h0;
    end else begin
      if (wr_cr1) begin
        cr1_q <= hwdata[6:0] & ~7'(1 << `LSR_CR1_RSV);
      end
      if (wr_cr2) begin
        cr2_q <= hwdata[7:0];
      end
      if (wr_lincr) begin
        lincr_q <= {hwdata[`LSR_LIN_EN], hwdata[`LSR_LIN_SLV], hwdata[`LSR_LIN_HDM],
                    hwdata[`LSR_LIN_HIE]};
      end
      if (wr_divm) begin
        div_m_q <= hwdata[7:0];
      end
      if (wr_divf) begin
        div_f_q <= hwdata[3:0];
      end
    end
  end

  // Receive line: three flops, a level change is taken when the last two agree
  logic rx_m_q, rx_s2_q, rx_s3_q, rx_q, rx_prev_q, rx_fall;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_m_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_m_q <= rx_line;
      rx_s2_q <= rx_m_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_q <= rx_s3_q;
      end
      rx_prev_q <= rx_q;
    end
  end
  assign rx_fall = rx_prev_q && !rx_q;

  // Character receiver
  lsr_char_e ch_q;
  lsr_hdr_e hdr_q;
  logic [3:0] phase_q;
  logic [2:0] bit_q;
  logic [2:0] samp_q;
  logic [7:0] shift_q;
  logic ones_q, noisy_q, tick, ch_en, start_det, bit_end, bit_val, char_done;

  assign ch_en = !(slave_mode && (hdr_q == H_SYNC || hdr_q == H_GAP));
  assign start_det = ch_q == CH_IDLE && ch_en && !rx_q;
  assign bit_end = tick && phase_q == 4'hf;
  assign bit_val = maj3(samp_q);
  assign char_done = ch_q == CH_STOP && bit_end;

  lsr_baud_gen #(
    .MANT_W(8),
    .FRAC_W(4)
  ) u_baud (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .divisor({div_m_q, div_f_q}),
    .realign(start_det),
    .tick(tick)
  );

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ch_q <= CH_IDLE;
      phase_q <= 4'h0;
      bit_q <= 3'h0;
      samp_q <= 3'h0;
      shift_q <= 8'h00;
      ones_q <= 1'b0;
      noisy_q <= 1'b0;
    end else if (!ch_en) begin
      ch_q <= CH_IDLE;
    end else if (start_det) begin
      ch_q <= CH_START;
      phase_q <= 4'h0;
      ones_q <= 1'b0;
      noisy_q <= 1'b0;
    end else if (tick && ch_q != CH_IDLE) begin
      phase_q <= phase_q + 4'h1;
      if (phase_q >= `LSR_SAMP_FIRST && phase_q <= `LSR_SAMP_LAST) begin
        samp_q[2'(phase_q - `LSR_SAMP_FIRST)] <= rx_q;
      end
      if (bit_end) begin
        noisy_q <= noisy_q || (samp_q != 3'h0 && samp_q != 3'h7);
        case (ch_q)
          CH_START: begin
            ch_q <= bit_val ? CH_IDLE : CH_DATA;
            bit_q <= 3'h0;
          end
          CH_DATA: begin
            shift_q <= {bit_val, shift_q[7:1]};
            ones_q <= ones_q || bit_val;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              ch_q <= CH_STOP;
            end
          end
          default: begin
            ch_q <= CH_IDLE;
          end
        endcase
      end
    end
  end

  // Break and idle-line counters on oversampling ticks
  logic [7:0] lo_cnt_q;
  logic [7:0] hi_cnt_q;
  logic brk_pulse, idle_pulse, idle_arm_q;

  assign brk_pulse = slave_mode && tick && !rx_q && lo_cnt_q == BRK_TICKS - 8'h01;
  assign idle_pulse = idle_arm_q && tick && rx_q && hi_cnt_q == IDLE_TICKS - 8'h01;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lo_cnt_q <= 8'h00;
      hi_cnt_q <= 8'h00;
      idle_arm_q <= 1'b0;
    end else begin
      if (rx_q) begin
        lo_cnt_q <= 8'h00;
      end else if (tick && lo_cnt_q != BRK_TICKS) begin
        lo_cnt_q <= lo_cnt_q + 8'h01;
      end
      if (!rx_q) begin
        hi_cnt_q <= 8'h00;
      end else if (tick && hi_cnt_q != IDLE_TICKS) begin
        hi_cnt_q <= hi_cnt_q + 8'h01;
      end
      if (char_done) begin
        idle_arm_q <= 1'b1;
      end else if (idle_pulse) begin
        idle_arm_q <= 1'b0;
      end
    end
  end

  // Header sequencing: break, synch measurement, identifier, timeout
  logic [2:0] edge_q;
  logic [14:0] meas_q;
  logic [14:0] sync_meas_q;
  logic [9:0] tmo_q;
  logic tmo_on_q, blocked_q, sync_end, sync_ovf, tmo_pulse, id_done;

  assign sync_end = hdr_q == H_SYNC && lsf_q && !blocked_q && rx_fall && edge_q == LAST_EDGE;
  assign sync_ovf = hdr_q == H_SYNC && !blocked_q && edge_q != 3'h0 && meas_q == 15'h7fff;
  assign tmo_pulse = tmo_on_q && tick && tmo_q == TMO_TICKS - 10'h001;
  assign id_done = hdr_q == H_ID && char_done;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hdr_q <= H_IDLE;
      edge_q <= 3'h0;
      meas_q <= 15'h0000;
      sync_meas_q <= 15'h0000;
      blocked_q <= 1'b0;
    end else if (brk_pulse) begin
      hdr_q <= H_SYNC;
      edge_q <= 3'h0;
      meas_q <= 15'h0000;
      blocked_q <= 1'b0;
    end else begin
      case (hdr_q)
        H_SYNC: begin
          if (!lsf_q || tmo_pulse) begin
            hdr_q <= H_IDLE;
          end else if (sync_ovf) begin
            blocked_q <= 1'b1;
          end else if (!blocked_q) begin
            if (edge_q != 3'h0) begin
              meas_q <= meas_q + 15'h0001;
            end
            if (rx_fall) begin
              edge_q <= edge_q + 3'h1;
            end
            if (sync_end) begin
              sync_meas_q <= meas_q;
              hdr_q <= H_GAP;
            end
          end
        end
        H_GAP: begin
          if (tmo_pulse) begin
            hdr_q <= H_IDLE;
          end else if (rx_q) begin
            hdr_q <= H_ID;
          end
        end
        H_ID: begin
          if (id_done || tmo_pulse) begin
            hdr_q <= H_IDLE;
          end
        end
        default: begin
          hdr_q <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tmo_q <= 10'h000;
      tmo_on_q <= 1'b0;
    end else if (brk_pulse) begin
      tmo_q <= 10'h000;
      tmo_on_q <= hdr_method;
    end else if (tmo_pulse || id_done || sync_ovf || (hdr_q == H_SYNC && !lsf_q)) begin
      tmo_on_q <= 1'b0;
    end else if (tmo_on_q && tick) begin
      tmo_q <= tmo_q + 10'h001;
    end
  end

  // Status flags and the data register
  lsr_flags_s fl_q;
  logic [7:0] data_q;
  logic seen_q, muted, deliver, id_wake, overrun, fe_set, clr_seq, hdf_clr;

  assign muted = mute_q && slave_mode;
  assign id_wake = id_done && muted && hdr_method;
  assign deliver = char_done && ch_en && (!muted || id_wake);
  assign overrun = deliver && fl_q.rx_full;
  assign fe_set = deliver && !bit_val && (!slave_mode || ones_q);
  assign clr_seq = seen_q && rd_data;
  assign hdf_clr = seen_q && rd_lincr;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fl_q <= '0;
      data_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      if (rd_status) begin
        seen_q <= 1'b1;
      end else if (rd_data || rd_lincr) begin
        seen_q <= 1'b0;
      end
      if (deliver && !fl_q.rx_full) begin
        data_q <= shift_q;
        fl_q.rx_full <= 1'b1;
      end else if (rd_data) begin
        fl_q.rx_full <= 1'b0;
      end
      if (idle_pulse) begin
        fl_q.idle <= 1'b1;
      end else if (clr_seq) begin
        fl_q.idle <= 1'b0;
      end
      if (overrun || sync_ovf || tmo_pulse) begin
        fl_q.hdr_err <= 1'b1;
      end else if (clr_seq && !lsf_q) begin
        fl_q.hdr_err <= 1'b0;
      end
      if (deliver && master_mode && noisy_q) begin
        fl_q.noise <= 1'b1;
      end else if (clr_seq) begin
        fl_q.noise <= 1'b0;
      end
      if (fe_set) begin
        fl_q.frame_err <= 1'b1;
      end else if (clr_seq) begin
        fl_q.frame_err <= 1'b0;
      end
      if (id_done && cr1_q[`LSR_CR1_PCE] && !id_parity_ok(shift_q)) begin
        fl_q.par_err <= 1'b1;
      end else if (clr_seq) begin
        fl_q.par_err <= 1'b0;
      end
    end
  end

  // Ninth received bit: plain data, left without reset
  always_ff @(posedge clk_sys) begin
    if (deliver) begin
      rx_ninth_q <= bit_val;
    end
  end

  // Synch state, header detect and mute; hardware set or wake clear wins over software write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lsf_q <= 1'b0;
      hdf_q <= 1'b0;
      mute_q <= 1'b0;
    end else begin
      if (brk_pulse) begin
        lsf_q <= 1'b1;
      end else if (sync_end || tmo_pulse) begin
        lsf_q <= 1'b0;
      end else if (wr_lincr && !hwdata[`LSR_LIN_LSF]) begin
        lsf_q <= 1'b0;
      end
      if ((brk_pulse && !hdr_method) || (id_done && hdr_method)) begin
        hdf_q <= 1'b1;
      end else if (hdf_clr) begin
        hdf_q <= 1'b0;
      end
      if ((brk_pulse && muted && !hdr_method) || id_wake) begin
        mute_q <= 1'b0;
      end else if (wr_cr2) begin
        mute_q <= hwdata[`LSR_CR2_MUTE];
      end
    end
  end

  // Read mux
  function automatic logic [7:0] rd_mux(input logic [7:0] ofs);
    case (ofs)
      `LSR_OFS_STATUS: return {STATUS_RST[7:6], fl_q};
      `LSR_OFS_DATA: return data_q;
      `LSR_OFS_CR1: return {rx_ninth_q, cr1_q};
      `LSR_OFS_CR2: return {cr2_q[7:2], mute_q, cr2_q[0]};
      `LSR_OFS_LINCR: return {1'b0, lincr_q[3:2], 1'b0, lincr_q[1:0], hdf_q, lsf_q};
      `LSR_OFS_DIVM: return div_m_q;
      `LSR_OFS_DIVF: return {4'h0, div_f_q};
      `LSR_OFS_SMEAS: return sync_meas_q[14:7];
      default: return 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (req.rd) begin
      hrdata_q <= {24'h00_0000, rd_mux(req.ofs)};
    end
  end

  assign serial_irq = (cr2_q[`LSR_CR2_RIE] && (fl_q.rx_full || fl_q.hdr_err))
    || (cr1_q[`LSR_CR1_PIE] && fl_q.par_err)
    || (lincr_q[0] && hdf_q);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_status_read;
    rd_status;
  endsequence
  sequence s_data_read;
    rd_data && !rd_status;
  endsequence
  a_break_length: assert property (brk_pulse |-> lo_cnt_q == 8'haf && !rx_q)
    else $error("break taken before eleven bit times");
  a_zero_char_safe: assert property (lo_cnt_q < 8'ha0 |-> !brk_pulse)
    else $error("short low period taken as break");
  a_start_realign: assert property (start_det |=> ch_q == CH_START && phase_q == 4'h0)
    else $error("phase not restarted on start bit");
  a_lsf_on_break: assert property (brk_pulse |=> lsf_q && hdr_q == H_SYNC)
    else $error("synch state not entered on break");
  a_hdr_err_irq: assert property (fl_q.hdr_err && cr2_q[5] |-> serial_irq)
    else $error("header error without interrupt");
  a_fe_slave_cause: assert property (
    slave_mode && $rose(fl_q.frame_err) |-> $past(ones_q) && !$past(bit_val))
    else $error("slave framing error without recessive bit");
  a_fe_clear_seq: assert property (
    s_status_read ##[1:4] s_data_read ##0 (seen_q && !fe_set) |=> !fl_q.frame_err)
    else $error("framing error not cleared by sequence");
  a_parity_gate: assert property ($rose(fl_q.par_err) |-> $past(cr1_q[2]))
    else $error("parity error with parity check off");
  a_mute_discard: assert property (char_done && muted && !id_wake |=> !$rose(fl_q.rx_full))
    else $error("muted receiver delivered a character");
  a_hdr_err_hold: assert property (
    fl_q.hdr_err && lsf_q && !wr_lincr |=> fl_q.hdr_err)
    else $error("header error cleared while blocked");
  a_sync_count: assert property (sync_end |=> sync_meas_q == $past(meas_q) && !lsf_q)
    else $error("synch measurement not stored");
endmodule

// *** tb/lsr_lin_master.sv ***
/*
  LIN master model driving the slave receive line.
  Assumes the slave bit time is BIT_CLK clock cycles.
*/
`timescale 1ns/10ps
module lsr_lin_master #(
  parameter int BIT_CLK = 32
) (
  // Clock
  input wire logic clk_sys,
  // LIN line
  output logic rx_line
);
  // Recessive idle level, as the bus pull-up gives
  initial rx_line = 1'b1;
  task automatic bits(input int n, input logic v);
    rx_line <= v;
    repeat (n * BIT_CLK) @(posedge clk_sys);
  endtask
  // LSB first; stop level is selectable to provoke framing faults
  task automatic frame(input logic [7:0] b, input logic stp);
    bits(1, 1'b0);
    for (int i = 0; i < 8; i++) bits(1, b[i]);
    bits(1, stp);
    bits(2, 1'b1);
  endtask
  task automatic brk();
    bits(13, 1'b0);
    bits(2, 1'b1);
  endtask
endmodule

// *** tb/tb.sv ***
/*
  Self-checking bench of the LIN slave receiver over AHB-Lite.
  Assumes a divisor of 2.0, so one bit is 32 clocks.
*/
`timescale 1ns/10ps
module tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic rx_line;
  logic serial_irq;
  int err_total = 0;
  int n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  lsr_receiver lsr_receiver_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rx_line(rx_line), .serial_irq(serial_irq)
  );
  lsr_lin_master lsr_lin_master_i (.clk_sys(clk_sys), .rx_line(rx_line));
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t: got %h, expected %h", $time, s, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] r);
    @(posedge clk_sys);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  // Noise is undefined in slave mode and the ninth bit is unreset: both masked
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 8'h00, r);
    if (a == 8'h00) r[2] = 1'b0;
    if (a == 8'h08) r[7] = 1'b0;
    chk(r, {24'h0, e});
  endtask
  function automatic logic [7:0] idb(input logic [5:0] i);
    idb = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h00, 8'hc0);
    chk({hreadyout, hresp}, 2'b10);
    rd(8'h08, 8'h00);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h7d);
    rd(8'h20, 8'h00);
    wr(8'h08, 8'h05);
    wr(8'h14, 8'h02);
    wr(8'h18, 8'h00);
    wr(8'h10, 8'h60);
    wr(8'h0c, 8'h20);
    lsr_lin_master_i.frame(8'h00, 1'b1);
    rd(8'h10, 8'h60);
    // Ten dominant bits: stop low, all zero, and lands on a full buffer
    lsr_lin_master_i.bits(10, 1'b0);
    lsr_lin_master_i.bits(2, 1'b1);
    rd(8'h00, 8'he8);
    chk(serial_irq, 1'b1);
    rd(8'h04, 8'h00);
    rd(8'h00, 8'hc0);
    // The all-low character ahead of a break is delivered, never as a framing error
    lsr_lin_master_i.brk();
    rd(8'h00, 8'he0);
    rd(8'h10, 8'h63);
    rd(8'h10, 8'h61);
    rd(8'h04, 8'h00);
    lsr_lin_master_i.frame(8'h55, 1'b1);
    lsr_lin_master_i.frame(idb(6'h01), 1'b1);
    rd(8'h10, 8'h60);
    rd(8'h00, 8'he0);
    rd(8'h04, idb(6'h01));
    wr(8'h0c, 8'h00);
    lsr_lin_master_i.brk();
    rd(8'h04, 8'h00);
    lsr_lin_master_i.frame(8'h55, 1'b1);
    lsr_lin_master_i.frame(idb(6'h2a) ^ 8'h80, 1'b1);
    rd(8'h00, 8'he1);
    chk(serial_irq, 1'b1);
    rd(8'h04, idb(6'h2a) ^ 8'h80);
    rd(8'h00, 8'hc0);
    chk(serial_irq, 1'b0);
    lsr_lin_master_i.frame(8'h01, 1'b0);
    rd(8'h00, 8'he2);
    rd(8'h04, 8'h01);
    rd(8'h00, 8'hc0);
    wr(8'h0c, 8'h02);
    lsr_lin_master_i.frame(8'ha5, 1'b1);
    rd(8'h00, 8'hc0);
    lsr_lin_master_i.brk();
    rd(8'h0c, 8'h00);
    wr(8'h10, 8'h62);
    rd(8'h10, 8'h62);
    // Identifier method: a muted slave wakes only on a whole header
    wr(8'h10, 8'h68);
    wr(8'h0c, 8'h02);
    lsr_lin_master_i.brk();
    lsr_lin_master_i.frame(8'h55, 1'b1);
    lsr_lin_master_i.frame(idb(6'h3c), 1'b1);
    rd(8'h0c, 8'h00);
    rd(8'h04, idb(6'h3c));
    // No synch field after the break: the header times out
    lsr_lin_master_i.brk();
    lsr_lin_master_i.bits(60, 1'b1);
    rd(8'h00, 8'hf8);
    rd(8'h10, 8'h6a);
    finish_test();
  end
endmodule
